// [acs_pkg.sv]
`default_nettype none
package acs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] ACS_OFF_CTRL_TWO   = 8'h01;
  localparam logic [7:0] ACS_OFF_CTRL_THREE = 8'h02;
  localparam logic [7:0] ACS_OFF_MUX_SEL    = 8'h03;
  localparam logic [7:0] ACS_OFF_SCAN_MASK  = 8'h04;
  localparam logic [7:0] ACS_OFF_BUF_BASE   = 8'h10;

  // ---------------------------------------------------------------
  // Writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ACS_MASK_CTRL_ONE   = 16'h0008;
  localparam logic [15:0] ACS_MASK_CTRL_TWO   = 16'hF73F;
  localparam logic [15:0] ACS_MASK_CTRL_THREE = 16'h1FBF;
  localparam logic [15:0] ACS_MASK_MUX_SEL    = 16'hFFFF;
  localparam logic [15:0] ACS_RST_REG         = 16'h0000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ACS_B_CONVERSION_ACTIVE_FLAG_ACTIVE = 0;
  localparam int ACS_B_START       = 1;
  localparam int ACS_B_SIMSAMPLE   = 3;
  localparam int ACS_F_REF_LO      = 13;
  localparam int ACS_B_OFFSET      = 12;
  localparam int ACS_B_SCAN_EN     = 10;
  localparam int ACS_F_PATHS_LO    = 8;
  localparam int ACS_B_FILL_HALF   = 7;
  localparam int ACS_F_SAMPLES_PER_IRQ_LO     = 2;
  localparam int ACS_B_SPLIT       = 1;
  localparam int ACS_B_ALT         = 0;
  localparam int ACS_F_AUTO_SAMPLE_TIME_LO     = 8;
  localparam int ACS_B_RC_CLK      = 7;
  localparam int ACS_F_DIV_LO      = 0;
  localparam int ACS_F_SET_B_LO    = 8;

  // ---------------------------------------------------------------
  // Encodings and sizes
  // ---------------------------------------------------------------
  localparam logic [2:0] ACS_REF_MAX      = 3'h3;
  localparam logic [3:0] ACS_AUX_POS_LOW  = 4'h0;
  localparam logic [3:0] ACS_AUX_POS_HIGH = 4'h3;
  localparam logic [3:0] ACS_AUX_NEG_LOW  = 4'h6;
  localparam logic [3:0] ACS_AUX_NEG_HIGH = 4'h9;
  localparam int          ACS_BUF_DEPTH   = 16;
  localparam int          ACS_RES_W       = 10;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERSION_ACTIVE_FLAG   = 2'b10,
    ST_WAIT   = 2'b11
  } acs_state_t;

  typedef struct packed {
    logic [3:0] primPos;
    logic       primNegIsPin;
    logic [2:0][3:0] auxPos;
    logic [2:0][3:0] auxNeg;
    logic       auxNegIsRef;
  } acs_mux_t;

  typedef struct packed {
    logic       sampling;
    logic       convStart;
    logic [1:0] pathIdx;
    logic       offsetShort;
    logic [1:0] refPair;
  } acs_core_t;

endpackage
`default_nettype wire

// [acs_tad_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire logic       rcSel,
  input  wire logic [5:0] divider,
  input  wire logic       rcRise,
  // Conversion clock tick
  output logic            tadTick
);

  logic [6:0] divCnt_r;
  logic [6:0] divLimit;

  assign divLimit = {divider, 1'b1};

  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt_r <= 7'h00;
    end else if (ce) begin
      if (rcSel || divCnt_r >= divLimit) begin
        divCnt_r <= 7'h00;
      end else begin
        divCnt_r <= divCnt_r + 7'h01;
      end
    end
  end

  assign tadTick = ce && (rcSel ? rcRise : (divCnt_r >= divLimit));

endmodule
`default_nettype wire

// [acs_seq.sv]
// Notes on behaviour
// - Busy flag high during conversion, hardware cleared
// - Reference pair select, unused codes use supply
// - Offset calibration shorts sample-hold inputs
// - Scan enable steps primary positive in set A
// - Path count: one, two or four paths
// - Fill status shows which half is filling
// - Interrupt after every (field+1) conversions
// - Split mode alternates start at 0x0, 0x8
// - Alternate mode swaps set A and B
// - Auto sample time in conversion clock periods
// - Clock source: RC oscillator or system
// - Divider period is 2*(field+1) cycles
// - Aux negative inputs 9-11, 6-8 or reference
// - Aux positive inputs 3-5 or 0-2
// - Primary negative: input 1 or reference
// - Primary positive input equals four-bit code
// - Set B fields mirror set A encodings
// - Unimplemented bits read zero, ignore writes
// - Simultaneous sampling of all enabled paths
// - Scan includes only masked-in inputs
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module acs_seq
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [15:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [15:0]          regRdData,
  // Converter core
  input  wire logic                 coreDone,
  input  wire logic [ACS_RES_W-1:0] coreResult,
  input  wire logic                 rcClk,
  output acs_core_t                 coreCtl,
  output acs_mux_t                  muxSel,
  // Events and status
  output logic                      irqPulse,
  output logic                      convActive
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0]          ctrlOne_r;
  logic [15:0]          ctrlTwo_r;
  logic [15:0]          ctrlThree_r;
  logic [15:0]          muxSel_r;
  logic [15:0]          scanMask_r;
  logic [15:0]          regRdData_r;
  logic [ACS_RES_W-1:0] resBuf [ACS_BUF_DEPTH];

  acs_state_t           state_r;
  logic [4:0]           tadCnt_r;
  logic [1:0]           pathIdx_r;
  logic [3:0]           wrPtr_r;
  logic [3:0]           sampleCnt_r;
  logic                 fillHalf_r;
  logic                 useSetB_r;
  logic [3:0]           scanCur_r;
  logic                 irqPulse_r;
  logic                 convStart_r;
  logic                 startReq;

  logic                 doneS1_r, doneS2_r, doneS3_r;
  logic [ACS_RES_W-1:0] resS1_r, resS2_r;
  logic                 rcS1_r, rcS2_r, rcS3_r;
  logic                 doneRise;
  logic                 rcRise;
  logic                 tadTick;

  // Field views
  logic [2:0] refCode;
  logic [1:0] pathCode;
  logic [3:0] samples_per_irq;
  logic       splitMode;
  logic       altMode;
  logic       scanEn;
  logic       simSample;
  logic [4:0] auto_sample_time;
  logic [1:0] lastPath;
  logic [7:0] setSel;
  logic       lastConv;

  assign refCode   = ctrlTwo_r[ACS_F_REF_LO +: 3];
  assign pathCode  = ctrlTwo_r[ACS_F_PATHS_LO +: 2];
  assign samples_per_irq      = ctrlTwo_r[ACS_F_SAMPLES_PER_IRQ_LO +: 4];
  assign splitMode = ctrlTwo_r[ACS_B_SPLIT];
  assign altMode   = ctrlTwo_r[ACS_B_ALT];
  assign scanEn    = ctrlTwo_r[ACS_B_SCAN_EN];
  assign simSample = ctrlOne_r[ACS_B_SIMSAMPLE];
  assign auto_sample_time      = ctrlThree_r[ACS_F_AUTO_SAMPLE_TIME_LO +: 5];

  assign lastPath = pathCode[1] ? 2'h3 : {1'b0, pathCode[0]};
  assign setSel   = useSetB_r ? muxSel_r[ACS_F_SET_B_LO +: 8] : muxSel_r[7:0];
  assign startReq = regWr && regAddr == ACS_OFF_CTRL_ONE && regWrData[ACS_B_START];
  assign lastConv = pathIdx_r == lastPath;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      doneS1_r <= 1'b0;
      doneS2_r <= 1'b0;
      doneS3_r <= 1'b0;
      resS1_r  <= '0;
      resS2_r  <= '0;
      rcS1_r   <= 1'b0;
      rcS2_r   <= 1'b0;
      rcS3_r   <= 1'b0;
    end else if (ce) begin
      doneS1_r <= coreDone;
      doneS2_r <= doneS1_r;
      doneS3_r <= doneS2_r;
      resS1_r  <= coreResult;
      resS2_r  <= resS1_r;
      rcS1_r   <= rcClk;
      rcS2_r   <= rcS1_r;
      rcS3_r   <= rcS2_r;
    end
  end

  assign doneRise = doneS2_r && !doneS3_r && state_r == ST_WAIT;
  assign rcRise   = rcS2_r && !rcS3_r;

  // ---------------------------------------------------------------
  // Conversion clock
  // ---------------------------------------------------------------
  acs_tad_gen uTad (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .rcSel   (ctrlThree_r[ACS_B_RC_CLK]),
    .divider (ctrlThree_r[ACS_F_DIV_LO +: 6]),
    .rcRise  (rcRise),
    .tadTick (tadTick)
  );

  // ---------------------------------------------------------------
  // Scan order
  // ---------------------------------------------------------------
  // Ascending with wrap
  function automatic logic [3:0] nextScan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] idx;
    logic       found;
    nextScan = cur;
    found    = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      idx = cur + 4'(i);
      if (!found && mask[idx]) begin
        nextScan = idx;
        found    = 1'b1;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Masked writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrlOne_r   <= ACS_RST_REG;
      ctrlTwo_r   <= ACS_RST_REG;
      ctrlThree_r <= ACS_RST_REG;
      muxSel_r    <= ACS_RST_REG;
      scanMask_r  <= ACS_RST_REG;
    end else if (ce && regWr) begin
      case (regAddr)
        ACS_OFF_CTRL_ONE:   ctrlOne_r   <= regWrData & ACS_MASK_CTRL_ONE;
        ACS_OFF_CTRL_TWO:   ctrlTwo_r   <= regWrData & ACS_MASK_CTRL_TWO;
        ACS_OFF_CTRL_THREE: ctrlThree_r <= regWrData & ACS_MASK_CTRL_THREE;
        ACS_OFF_MUX_SEL:    muxSel_r    <= regWrData & ACS_MASK_MUX_SEL;
        ACS_OFF_SCAN_MASK:  scanMask_r  <= regWrData;
        default:            ctrlOne_r   <= ctrlOne_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData_r <= 16'h0000;
    end else if (ce) begin
      regRdData_r <= 16'h0000;
      if (regRd) begin
        if (regAddr >= ACS_OFF_BUF_BASE && regAddr < ACS_OFF_BUF_BASE + 8'h10) begin
          regRdData_r <= {6'h00, resBuf[regAddr[3:0]]};
        end else begin
          case (regAddr)
            ACS_OFF_CTRL_ONE: begin
              regRdData_r <= ctrlOne_r;
              regRdData_r[ACS_B_CONVERSION_ACTIVE_FLAG_ACTIVE] <= convActive;
            end
            ACS_OFF_CTRL_TWO: begin
              regRdData_r <= ctrlTwo_r;
              regRdData_r[ACS_B_FILL_HALF] <= fillHalf_r;
            end
            ACS_OFF_CTRL_THREE: regRdData_r <= ctrlThree_r;
            ACS_OFF_MUX_SEL:    regRdData_r <= muxSel_r;
            ACS_OFF_SCAN_MASK:  regRdData_r <= scanMask_r;
            default:            regRdData_r <= 16'h0000;
          endcase
        end
      end
    end
  end

  assign regRdData = regRdData_r;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      tadCnt_r    <= 5'h00;
      pathIdx_r   <= 2'h0;
      convStart_r <= 1'b0;
    end else if (ce) begin
      convStart_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (startReq) begin
            state_r   <= ST_SAMPLE;
            tadCnt_r  <= 5'h00;
            pathIdx_r <= 2'h0;
          end
        end
        ST_SAMPLE: begin
          if (tadCnt_r >= auto_sample_time) begin
            state_r <= ST_CONVERSION_ACTIVE_FLAG;
          end else if (tadTick) begin
            tadCnt_r <= tadCnt_r + 5'h01;
          end
        end
        ST_CONVERSION_ACTIVE_FLAG: begin
          convStart_r <= 1'b1;
          state_r     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (doneRise) begin
            tadCnt_r <= 5'h00;
            if (lastConv) begin
              state_r <= ST_IDLE;
            end else begin
              pathIdx_r <= pathIdx_r + 2'h1;
              state_r   <= (simSample && lastPath != 2'h0) ? ST_CONVERSION_ACTIVE_FLAG : ST_SAMPLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign convActive = state_r == ST_CONVERSION_ACTIVE_FLAG || state_r == ST_WAIT;

  // ---------------------------------------------------------------
  // Alternate set and scan position
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      useSetB_r <= 1'b0;
      scanCur_r <= 4'h0;
    end else if (ce) begin
      if (regWr && (regAddr == ACS_OFF_SCAN_MASK || regAddr == ACS_OFF_CTRL_TWO)) begin
        scanCur_r <= nextScan(regAddr == ACS_OFF_SCAN_MASK ? regWrData : scanMask_r, 4'hF);
      end else if (doneRise && lastConv && scanEn && !useSetB_r) begin
        scanCur_r <= nextScan(scanMask_r, scanCur_r);
      end
      if (!altMode) begin
        useSetB_r <= 1'b0;
      end else if (doneRise && lastConv) begin
        useSetB_r <= !useSetB_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result buffer and interrupt count
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (ce && doneRise) begin
      resBuf[wrPtr_r] <= resS2_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r     <= 4'h0;
      sampleCnt_r <= 4'h0;
      fillHalf_r  <= 1'b0;
      irqPulse_r  <= 1'b0;
    end else if (ce) begin
      irqPulse_r <= 1'b0;
      if (doneRise) begin
        if (sampleCnt_r == samples_per_irq) begin
          irqPulse_r  <= 1'b1;
          sampleCnt_r <= 4'h0;
          if (splitMode) begin
            fillHalf_r <= !fillHalf_r;
            wrPtr_r    <= {!fillHalf_r, 3'h0};
          end else begin
            fillHalf_r <= 1'b0;
            wrPtr_r    <= 4'h0;
          end
        end else begin
          sampleCnt_r <= sampleCnt_r + 4'h1;
          wrPtr_r     <= splitMode ? {fillHalf_r, wrPtr_r[2:0] + 3'h1} : wrPtr_r + 4'h1;
        end
      end
    end
  end

  assign irqPulse = irqPulse_r;

  // ---------------------------------------------------------------
  // Core and multiplexer controls
  // ---------------------------------------------------------------
  always_comb begin
    coreCtl.sampling    = state_r == ST_SAMPLE;
    coreCtl.convStart   = convStart_r;
    coreCtl.pathIdx     = pathIdx_r;
    coreCtl.offsetShort = ctrlTwo_r[ACS_B_OFFSET];
    coreCtl.refPair     = refCode > ACS_REF_MAX ? 2'h0 : refCode[1:0];
  end

  assign muxSel.primPos      = (scanEn && !useSetB_r) ? scanCur_r : setSel[3:0];
  assign muxSel.primNegIsPin = setSel[4];
  assign muxSel.auxNegIsRef  = !setSel[7];

  for (genvar k = 0; k < 3; k++) begin : gAux
    assign muxSel.auxPos[k] = (setSel[5] ? ACS_AUX_POS_HIGH : ACS_AUX_POS_LOW) + 4'(k);
    assign muxSel.auxNeg[k] = (setSel[6] ? ACS_AUX_NEG_HIGH : ACS_AUX_NEG_LOW) + 4'(k);
  end

endmodule
`default_nettype wire

// [acs_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_seq_chk
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 ce,
  // Register port
  input wire logic [7:0]           regAddr,
  input wire logic [15:0]          regWrData,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [15:0]          regRdData,
  // Converter core
  input wire logic                 coreDone,
  input wire logic [ACS_RES_W-1:0] coreResult,
  input wire logic                 rcClk,
  input wire acs_core_t            coreCtl,
  input wire acs_mux_t             muxSel,
  // Events and status
  input wire logic                 irqPulse,
  input wire logic                 convActive
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);

  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not zero outside reply");
  two_unused_zero_a: assert property (
    regRd && regAddr == ACS_OFF_CTRL_TWO |=> (regRdData & ~(ACS_MASK_CTRL_TWO | 16'h0080)) == 16'h0000)
    else $error("unused bits set in control two");
  three_unused_zero_a: assert property (
    regRd && regAddr == ACS_OFF_CTRL_THREE |=> (regRdData & ~ACS_MASK_CTRL_THREE) == 16'h0000)
    else $error("unused bits set in control three");
  busy_flag_read_a: assert property (
    regRd && regAddr == ACS_OFF_CTRL_ONE |=> regRdData[0] == $past(convActive))
    else $error("busy flag read differs from state");
  start_while_busy_a: assert property (
    coreCtl.convStart |-> convActive && !coreCtl.sampling)
    else $error("conversion start without busy flag");
  ref_fallback_a: assert property (
    regWr && regAddr == ACS_OFF_CTRL_TWO && regWrData[15] |=> coreCtl.refPair == 2'h0)
    else $error("unused reference code not on supply");
  offset_short_a: assert property (
    regWr && regAddr == ACS_OFF_CTRL_TWO |=> coreCtl.offsetShort == $past(regWrData[12]))
    else $error("offset short does not follow write");
  aux_neg_map_a: assert property (
    !muxSel.auxNegIsRef |-> (muxSel.auxNeg[0] == 4'h6 || muxSel.auxNeg[0] == 4'h9)
      && muxSel.auxNeg[2] == muxSel.auxNeg[0] + 4'h2)
    else $error("aux negative inputs off their group");
  aux_pos_map_a: assert property (
    (muxSel.auxPos[0] == 4'h0 || muxSel.auxPos[0] == 4'h3) && muxSel.auxPos[1] == muxSel.auxPos[0] + 4'h1)
    else $error("aux positive inputs off their group");
  irq_after_done_a: assert property (
    irqPulse |-> $past(coreDone) && !$past(irqPulse))
    else $error("interrupt not tied to a completion");
endmodule

bind acs_seq acs_seq_chk chk_u (.mclk, .rst, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
  .coreDone, .coreResult, .rcClk, .coreCtl, .muxSel, .irqPulse, .convActive);
`default_nettype wire

// [acs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_core_model
  import acs_pkg::*;
(
  // Clock and control
  input  wire logic                 mclk,
  input  wire logic                 slow,
  input  wire acs_core_t            coreCtl,
  input  wire acs_mux_t             muxSel,
  // Core answers
  output logic                      coreDone,
  output logic      [ACS_RES_W-1:0] coreResult,
  output logic                      rcClk
);
  logic [ACS_RES_W-1:0] res;

  initial begin
    coreDone = 1'b0;
    coreResult = 10'h000;
    rcClk = 1'b0;
  end

  // Free-running oscillator, unrelated to mclk
  always #20.5 rcClk = ~rcClk;

  // Result names the path and the input it saw
  always @(posedge mclk) begin
    if (coreCtl.convStart === 1'b1) begin
      if (coreCtl.pathIdx == 2'h0) begin
        res = {coreCtl.pathIdx, muxSel.primPos, 4'h5};
      end else begin
        res = {coreCtl.pathIdx, muxSel.auxPos[coreCtl.pathIdx - 2'h1], 4'h5};
      end
      repeat (slow ? 6 : 1) @(posedge mclk);
      coreResult <= res;
      @(posedge mclk);
      coreDone <= 1'b1;
      repeat (4) @(posedge mclk);
      coreDone <= 1'b0;
      coreResult <= ~res;
    end
  end
endmodule
`default_nettype wire

// [acs_seq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_seq_tb
  import acs_pkg::*;
;
  logic        mclk, rst, ce, regWr, regRd, slow, coreDone, rcClk, irqPulse, convActive, sampPrev;
  logic [7:0]  regAddr, d;
  logic [15:0] regWrData, regRdData;
  logic [9:0]  coreResult;
  acs_core_t   coreCtl;
  acs_mux_t    muxSel;
  int          fail_count, total_checks, irqCount, sampCycles, sampRises, n;
  logic [15:0] cfg3 [3] = '{16'h0401, 16'h0403, 16'h0480};
  int          lo [3] = '{12, 24, 15};
  int          hi [3] = '{18, 34, 25};

  acs_seq dut_u (.mclk, .rst, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .coreDone, .coreResult, .rcClk, .coreCtl, .muxSel, .irqPulse, .convActive);
  acs_core_model core_u (.mclk, .slow, .coreCtl, .muxSel, .coreDone, .coreResult, .rcClk);

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    sampPrev <= coreCtl.sampling;
    if (irqPulse === 1'b1) irqCount <= irqCount + 1;
    if (coreCtl.sampling === 1'b1) sampCycles <= sampCycles + 1;
    if (coreCtl.sampling === 1'b1 && sampPrev === 1'b0) sampRises <= sampRises + 1;
  end

  function automatic logic [15:0] res(input logic [1:0] p, input logic [3:0] a);
    return {6'h00, p, a, 4'h5};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask

  task automatic waitDone;
    n = 0;
    #1;
    while ((convActive | coreCtl.sampling) !== 1'b0 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 600) fail_count++;
    @(posedge mclk);
    #1;
  endtask

  task automatic go(input logic [15:0] c1);
    sampCycles = 0;
    sampRises = 0;
    irqCount = 0;
    wr(ACS_OFF_CTRL_ONE, c1);
    waitDone;
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400us;
    fail_count++;
    conclude;
  end

  initial begin
    {mclk, regWr, regRd, slow, sampPrev} = 5'h00;
    ce = 1'b1;
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    {fail_count, total_checks, irqCount, sampCycles, sampRises} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, masks, unmapped place
    for (int a = 0; a < 5; a++) rd(8'(a), 16'h0000);
    wr(8'h08, 16'hFFFF);
    rd(8'h08, 16'h0000);
    wr(ACS_OFF_CTRL_ONE, 16'hFFFD);
    rd(ACS_OFF_CTRL_ONE, 16'h0008);
    wr(ACS_OFF_CTRL_TWO, 16'hFFFF);
    rd(ACS_OFF_CTRL_TWO, 16'hF73F);
    wr(ACS_OFF_CTRL_THREE, 16'hFFFF);
    rd(ACS_OFF_CTRL_THREE, 16'h1FBF);
    wr(ACS_OFF_MUX_SEL, 16'hFFFF);
    rd(ACS_OFF_MUX_SEL, 16'hFFFF);
    for (int c = 0; c < 8; c++) begin
      wr(ACS_OFF_CTRL_TWO, {3'(c), c[0], 12'h000});
      #1 chk(16'(coreCtl.refPair), c < 4 ? 16'(c) : 16'h0000);
      chk(16'(coreCtl.offsetShort), 16'(c[0]));
    end
    wr(ACS_OFF_CTRL_TWO, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      d = 8'(i * 37);
      wr(ACS_OFF_MUX_SEL, {8'h00, d});
      #1 chk(16'(muxSel.primPos), 16'(d[3:0]));
      chk(16'(muxSel.primNegIsPin), 16'(d[4]));
      chk(16'(muxSel.auxPos[2]), d[5] ? 16'h0005 : 16'h0002);
      chk(16'(muxSel.auxNegIsRef), 16'(!d[7]));
      if (d[7]) chk(16'(muxSel.auxNeg[1]), d[6] ? 16'h000A : 16'h0007);
    end
    // Clock enable low freezes the registers
    @(posedge mclk);
    ce <= 1'b0;
    wr(ACS_OFF_MUX_SEL, 16'h00FF);
    ce <= 1'b1;
    rd(ACS_OFF_MUX_SEL, {8'h00, d});
    // Single conversion, busy flag, interrupt count
    wr(ACS_OFF_CTRL_THREE, 16'h0000);
    wr(ACS_OFF_MUX_SEL, 16'h0007);
    wr(ACS_OFF_CTRL_ONE, 16'h0002);
    rd(ACS_OFF_CTRL_ONE, 16'h0001);
    waitDone;
    rd(ACS_OFF_CTRL_ONE, 16'h0000);
    rd(ACS_OFF_BUF_BASE, res(2'h0, 4'h7));
    wr(ACS_OFF_CTRL_TWO, 16'h0004);
    go(16'h0002);
    chk(16'(irqCount), 16'h0000);
    go(16'h0002);
    chk(16'(irqCount), 16'h0001);
    rd(ACS_OFF_BUF_BASE + 8'h01, res(2'h0, 4'h7));
    // Path counts, simultaneous and sequential sampling
    slow = 1'b1;
    wr(ACS_OFF_MUX_SEL, 16'h0025);
    wr(ACS_OFF_CTRL_TWO, 16'h020C);
    for (int s = 0; s < 2; s++) begin
      go(s == 0 ? 16'h000A : 16'h0002);
      chk(16'(sampRises), s == 0 ? 16'h0001 : 16'h0004);
      chk(16'(irqCount), 16'h0001);
      for (int p = 0; p < 4; p++) rd(ACS_OFF_BUF_BASE + 8'(p), res(2'(p), p == 0 ? 4'h5 : 4'(p + 2)));
    end
    wr(ACS_OFF_CTRL_TWO, 16'h0104);
    go(16'h0002);
    rd(ACS_OFF_BUF_BASE + 8'h01, res(2'h1, 4'h3));
    slow = 1'b0;
    // Split buffer and fill status
    wr(ACS_OFF_CTRL_TWO, 16'h0002);
    go(16'h0002);
    rd(ACS_OFF_CTRL_TWO, 16'h0082);
    rd(ACS_OFF_BUF_BASE, res(2'h0, 4'h5));
    wr(ACS_OFF_MUX_SEL, 16'h0009);
    go(16'h0002);
    rd(ACS_OFF_BUF_BASE + 8'h08, res(2'h0, 4'h9));
    rd(ACS_OFF_CTRL_TWO, 16'h0002);
    // Alternate sets
    wr(ACS_OFF_CTRL_TWO, 16'h0001);
    wr(ACS_OFF_MUX_SEL, 16'h1A03);
    for (int k = 0; k < 3; k++) begin
      go(16'h0002);
      rd(ACS_OFF_BUF_BASE, res(2'h0, k == 1 ? 4'hA : 4'h3));
      if (k == 0) chk(16'({muxSel.primNegIsPin, muxSel.primPos}), 16'h001A);
    end
    // Scan through masked inputs
    wr(ACS_OFF_MUX_SEL, 16'h0000);
    wr(ACS_OFF_CTRL_TWO, 16'h0400);
    wr(ACS_OFF_SCAN_MASK, 16'h0024);
    for (int j = 0; j < 3; j++) begin
      go(16'h0002);
      rd(ACS_OFF_BUF_BASE, res(2'h0, j == 1 ? 4'h5 : 4'h2));
    end
    // Sample time under each conversion clock
    wr(ACS_OFF_CTRL_TWO, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(ACS_OFF_CTRL_THREE, cfg3[m]);
      go(16'h0002);
      chk(16'(sampCycles >= lo[m] && sampCycles <= hi[m]), 16'h0001);
    end
    conclude;
  end
endmodule
`default_nettype wire
